//--- design/rtc_top.v
// Contract
// [R1] internal tags are the default mode
// [R2] hand each non-posted request a free tag
// [R3] user records each received tag
// [R4] stall non-posted requests at 64 outstanding
// [R5] external mode: user picks unique tags
// [R6] external mode: track, never check uniqueness/fullness
// [R7] one-cycle tag strobe with tag valid
// [R8] tags reported in request order, lag allowed
// [R9] free tag when final completion beat accepted
// [R10] hold non-posted without credit or tag
// [R11] two-bit non-posted credit availability codes
// [R12] credit outputs lag consumption by two cycles
// [R13] user subtracts credits sent last two cycles
// [R14] forward requests to link in order
// [R15] posted token valid in first beat
// [R16] pulse token once posted cannot be passed
// [R17] each completion is packet with descriptor
// [R18] dword mode: payload right after descriptor
// [R19] aligned mode: next beat at stored offset
// [R20] completion alignment needs request alignment too
// [R21] 12-byte descriptor in first beat
// [R22] each split completion its own packet
// [R23] 64-entry table matched by 6-bit tag
// [R24] bit 30 marks a request's last completion
// [R25] all tags free before first request
`include "rtc_defs.vh"

module rtc_top #(
  parameter user_tag_select_param = 0
) (
  // clock and reset
  input  wire                     clk,
  input  wire                     rst_b,
  // register bus
  input  wire [7:0]               avs_address,
  input  wire                     avs_read,
  input  wire                     avs_write,
  input  wire [31:0]              avs_writedata,
  output reg  [31:0]              avs_readdata,
  output reg                      avs_waitrequest,
  // request stream from user
  input  wire                     rq_valid,
  input  wire [`RTC_DW-1:0]       rq_data,
  input  wire                     rq_last,
  input  wire                     rq_np,
  input  wire                     rq_has_data,
  input  wire [`RTC_TAG_W-1:0]    rq_ext_tag,
  input  wire [`RTC_SB_W-1:0]     request_sideband,
  output reg                      request_stream_accept,
  // tag and credit reports
  output reg  [`RTC_TAG_W-1:0]    allocated_tag_out,
  output reg                      allocated_tag_strobe,
  output reg  [1:0]               np_header_credit_avail,
  output reg  [1:0]               np_data_credit_avail,
  output reg  [3:0]               posted_order_token_out,
  output reg                      posted_order_token_strobe,
  // requests toward the link
  output reg                      lnk_tx_valid,
  input  wire                     lnk_tx_ready,
  output reg  [`RTC_DW-1:0]       lnk_tx_data,
  output reg                      lnk_tx_first,
  output reg                      lnk_tx_last,
  output reg                      lnk_tx_np,
  output reg  [`RTC_TAG_W-1:0]    lnk_tx_tag,
  input  wire                     lnk_np_hdr_ret,
  input  wire                     lnk_np_data_ret,
  // completions from the link
  input  wire                     lnk_cpl_valid,
  output reg                      lnk_cpl_ready,
  input  wire                     lnk_cpl_sop,
  input  wire [`RTC_DESC_W-1:0]   lnk_cpl_desc,
  input  wire [`RTC_DW-1:0]       lnk_cpl_data,
  input  wire [3:0]               lnk_cpl_dws,
  input  wire                     lnk_cpl_eop,
  // completion stream to user
  output reg                      rc_valid,
  input  wire                     rc_ready,
  output reg  [`RTC_DW-1:0]       rc_data,
  output reg  [`RTC_NDW-1:0]      rc_keep,
  output reg                      rc_last,
  output reg                      rc_sof
);

  localparam [2:0] ST_HDR   = 3'b001;
  localparam [2:0] ST_DATA  = 3'b010;
  localparam [2:0] ST_FLUSH = 3'b100;

  function [`RTC_NDW-1:0] keep_of;
    input [3:0] n;
    reg   [15:0] t;
    begin
      t = (16'h0001 << n) - 16'h0001;
      keep_of = t[`RTC_NDW-1:0];
    end
  endfunction

  function [1:0] enc_cred;
    input [7:0] c;
    begin
      enc_cred = (c > 8'h02) ? 2'b11 : c[1:0]; // [R11]
    end
  endfunction

  // control registers
  reg                    user_tag_q;
  reg                    rc_aa_q;
  reg                    rq_aa_q;
  reg  [7:0]             hdr_cnt_q;
  reg  [7:0]             dat_cnt_q;
  wire                   rc_aa = rc_aa_q & rq_aa_q; // [R20]

  // tag store
  reg  [`RTC_TAG_W-1:0]  free_mem [0:`RTC_TAGS-1];
  reg  [2:0]             off_mem  [0:`RTC_TAGS-1];
  reg  [`RTC_TAGS-1:0]   busy_q;
  reg  [`RTC_CNT_W-1:0]  rd_ptr_q;
  reg  [`RTC_CNT_W-1:0]  wr_ptr_q;
  reg  [`RTC_CNT_W-1:0]  out_cnt_q;
  reg                    init_q;
  wire [`RTC_CNT_W-1:0]  free_cnt = wr_ptr_q - rd_ptr_q;
  wire [`RTC_TAG_W-1:0]  head_tag = free_mem[rd_ptr_q[5:0]];

  // request side
  reg                    in_pkt_q;
  reg  [3:0]             pkt_seq_q;
  reg                    pkt_seq_vld_q;
  reg                    tx_seq_vld_q;
  wire                   rq_take = rq_valid & request_stream_accept;
  wire                   np_take = rq_take & ~in_pkt_q & rq_np;
  wire [`RTC_TAG_W-1:0]  np_tag = user_tag_q ? rq_ext_tag : head_tag;
  wire                   tx_take = lnk_tx_valid & lnk_tx_ready;

  // completion side
  reg  [2:0]             st_q;
  reg  [`RTC_DW-1:0]     carry_q;
  reg  [3:0]             cnt_q;
  reg                    sof_pend_q;
  reg                    done_q;
  reg  [`RTC_TAG_W-1:0]  cpl_tag_q;
  reg                    rc_rel_q;
  reg  [`RTC_TAG_W-1:0]  rc_rel_tag_q;
  wire                   out_free = ~rc_valid | rc_ready;
  wire                   cpl_take = lnk_cpl_valid & lnk_cpl_ready;
  wire                   rel = rc_valid & rc_ready & rc_last & rc_rel_q; // [R9]

  // free list refill, init fills all 64 tags
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      init_q   <= 1'b1;
      wr_ptr_q <= {`RTC_CNT_W{1'b0}};
      rd_ptr_q <= {`RTC_CNT_W{1'b0}};
    end
    else
    begin
      if (init_q)
      begin
        free_mem[wr_ptr_q[5:0]] <= wr_ptr_q[5:0]; // [R25]
        wr_ptr_q <= wr_ptr_q + 7'h01;
        if (wr_ptr_q == 7'h3f)
          init_q <= 1'b0;
      end
      else if (rel && !user_tag_q)
      begin
        free_mem[wr_ptr_q[5:0]] <= rc_rel_tag_q; // [R9]
        wr_ptr_q <= wr_ptr_q + 7'h01;
      end
      if (np_take && !user_tag_q)
        rd_ptr_q <= rd_ptr_q + 7'h01; // [R2]
    end
  end

  // outstanding table
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_q    <= {`RTC_TAGS{1'b0}};
      out_cnt_q <= {`RTC_CNT_W{1'b0}};
    end
    else
    begin
      if (rel)
        busy_q[rc_rel_tag_q] <= 1'b0;
      if (np_take)
      begin
        busy_q[np_tag] <= 1'b1; // [R23] [R6]
        off_mem[np_tag] <= request_sideband[`RTC_SB_OFF_LO+:3]; // [R19]
      end
      out_cnt_q <= out_cnt_q + {6'h00, np_take} - {6'h00, rel};
    end
  end

  // credit counters and two-stage availability
  reg  [7:0]  hdr_nx;
  reg  [7:0]  dat_nx;
  wire        cred_wr = avs_write & ~avs_waitrequest & (avs_address[7:2] == `RTC_REG_CRED);
  always @*
  begin
    hdr_nx = hdr_cnt_q + {7'h00, lnk_np_hdr_ret} - {7'h00, np_take};
    dat_nx = dat_cnt_q + {7'h00, lnk_np_data_ret} - {7'h00, np_take & rq_has_data};
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hdr_cnt_q              <= `RTC_CRED_HDR_RST;
      dat_cnt_q              <= `RTC_CRED_DATA_RST;
      np_header_credit_avail <= 2'b00;
      np_data_credit_avail   <= 2'b00;
    end
    else
    begin
      hdr_cnt_q <= cred_wr ? avs_writedata[7:0] : hdr_nx;
      dat_cnt_q <= cred_wr ? avs_writedata[15:8] : dat_nx;
      np_header_credit_avail <= enc_cred(hdr_cnt_q); // [R12]
      np_data_credit_avail   <= enc_cred(dat_cnt_q); // [R12]
    end
  end

  // request acceptance: registered ready, one beat held in the link stage
  // trades half throughput for a flop-driven ready
  wire tags_ok = user_tag_q | (free_cnt > {6'h00, np_take}); // [R4] [R6]
  wire cred_ok = (hdr_nx != 8'h00) & (dat_nx != 8'h00); // [R10]
  wire tx_empty_nx = (~lnk_tx_valid | lnk_tx_ready) & ~rq_take;
  wire in_pkt_nx = rq_take ? ~rq_last : in_pkt_q;
  wire gate_ok = in_pkt_nx | (rq_valid & ~rq_np & ~rq_take) | (tags_ok & cred_ok);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      request_stream_accept <= 1'b0;
      in_pkt_q              <= 1'b0;
      lnk_tx_valid          <= 1'b0;
      lnk_tx_data           <= {`RTC_DW{1'b0}};
      lnk_tx_first          <= 1'b0;
      lnk_tx_last           <= 1'b0;
      lnk_tx_np             <= 1'b0;
      lnk_tx_tag            <= {`RTC_TAG_W{1'b0}};
      pkt_seq_q             <= 4'h0;
      pkt_seq_vld_q         <= 1'b0;
      tx_seq_vld_q          <= 1'b0;
      allocated_tag_out     <= {`RTC_TAG_W{1'b0}};
      allocated_tag_strobe  <= 1'b0;
      posted_order_token_out    <= 4'h0;
      posted_order_token_strobe <= 1'b0;
    end
    else
    begin
      request_stream_accept <= ~init_q & tx_empty_nx & gate_ok; // [R4] [R10] [R25]
      in_pkt_q <= in_pkt_nx;
      if (tx_take)
        lnk_tx_valid <= 1'b0;
      if (rq_take)
      begin
        lnk_tx_valid <= 1'b1; // [R14]
        lnk_tx_data  <= rq_data;
        lnk_tx_first <= ~in_pkt_q;
        lnk_tx_last  <= rq_last;
        lnk_tx_np    <= rq_np;
        if (!in_pkt_q)
        begin
          lnk_tx_tag    <= np_tag;
          pkt_seq_q     <= request_sideband[`RTC_SB_SEQ_LO+:4]; // [R15]
          pkt_seq_vld_q <= request_sideband[`RTC_SB_SEQ_VLD] & ~rq_np;
          tx_seq_vld_q  <= request_sideband[`RTC_SB_SEQ_VLD] & ~rq_np;
        end
        else
          tx_seq_vld_q  <= pkt_seq_vld_q;
      end
      allocated_tag_strobe <= np_take & ~user_tag_q; // [R7] [R8]
      if (np_take && !user_tag_q)
        allocated_tag_out <= head_tag; // [R2]
      // past the link hand-off nothing behind can overtake it
      posted_order_token_strobe <= tx_take & lnk_tx_last & tx_seq_vld_q; // [R16]
      if (tx_take && lnk_tx_last && tx_seq_vld_q)
        posted_order_token_out <= pkt_seq_q; // [R16]
    end
  end

  // completion framing
  wire [`RTC_TAG_W-1:0] h_tag = lnk_cpl_desc[`RTC_D_TAG_LO+:`RTC_TAG_W];
  wire [12:0]           h_bc  = lnk_cpl_desc[`RTC_D_BC_LO+:13];
  wire [10:0]           h_dwc = lnk_cpl_desc[`RTC_D_DWC_LO+:11];
  wire [3:0]            h_err = lnk_cpl_desc[`RTC_D_ERR_LO+:4];
  wire                  h_hit = busy_q[h_tag]; // [R23]
  wire [3:0]            h_err_o = (h_hit || h_err != `RTC_ERR_NORMAL) ? h_err : `RTC_ERR_BADTAG;
  wire                  h_done = h_hit & ((h_err != `RTC_ERR_NORMAL) | ({h_dwc, 2'b00} >= h_bc));
  wire [`RTC_DW-1:0]    h_desc = {160'h0, lnk_cpl_desc[95:31], h_done,
                                  lnk_cpl_desc[29:16], h_err_o, lnk_cpl_desc[11:0]}; // [R24]

  wire [`RTC_NDW-1:0]   in_keep = keep_of(lnk_cpl_dws);
  wire [`RTC_DW-1:0]    in_mask;
  genvar g;
  generate
    for (g = 0; g < `RTC_NDW; g = g + 1)
    begin : g_mask
      assign in_mask[g*32+:32] = {32{in_keep[g]}};
    end
  endgenerate

  wire [2*`RTC_DW-1:0]  merged = {`RTC_DW'h0, carry_q} |
                                 ({`RTC_DW'h0, lnk_cpl_data & in_mask} << {cnt_q, 5'b00000});
  wire [4:0]            total = {1'b0, cnt_q} + {1'b0, lnk_cpl_dws};

  always @*
  begin
    case (st_q)
      ST_HDR:   lnk_cpl_ready = out_free;
      ST_DATA:  lnk_cpl_ready = out_free;
      ST_FLUSH: lnk_cpl_ready = 1'b0;
      default:  lnk_cpl_ready = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q         <= ST_HDR;
      carry_q      <= {`RTC_DW{1'b0}};
      cnt_q        <= 4'h0;
      sof_pend_q   <= 1'b0;
      done_q       <= 1'b0;
      cpl_tag_q    <= {`RTC_TAG_W{1'b0}};
      rc_valid     <= 1'b0;
      rc_data      <= {`RTC_DW{1'b0}};
      rc_keep      <= {`RTC_NDW{1'b0}};
      rc_last      <= 1'b0;
      rc_sof       <= 1'b0;
      rc_rel_q     <= 1'b0;
      rc_rel_tag_q <= {`RTC_TAG_W{1'b0}};
    end
    else
    begin
      if (rc_valid && rc_ready)
        rc_valid <= 1'b0;
      case (st_q)
        ST_HDR:
        begin
          if (cpl_take && lnk_cpl_sop)
          begin
            done_q    <= h_done;
            cpl_tag_q <= h_tag;
            if (h_dwc == 11'h000 || rc_aa)
            begin
              // descriptor alone in the first beat
              rc_valid     <= 1'b1; // [R17] [R21] [R22]
              rc_data      <= h_desc;
              rc_keep      <= keep_of(`RTC_DESC_DWORDS);
              rc_sof       <= 1'b1;
              rc_last      <= (h_dwc == 11'h000);
              rc_rel_q     <= h_done & (h_dwc == 11'h000);
              rc_rel_tag_q <= h_tag;
              carry_q      <= {`RTC_DW{1'b0}};
              cnt_q        <= {1'b0, off_mem[h_tag]}; // [R19]
              sof_pend_q   <= 1'b0;
              if (h_dwc != 11'h000)
                st_q <= ST_DATA;
            end
            else
            begin
              carry_q    <= h_desc; // [R18]
              cnt_q      <= `RTC_DESC_DWORDS;
              sof_pend_q <= 1'b1;
              st_q       <= ST_DATA;
            end
          end
        end
        ST_DATA:
        begin
          if (cpl_take)
          begin
            if (total >= 5'h08 || lnk_cpl_eop)
            begin
              rc_valid     <= 1'b1;
              rc_data      <= merged[`RTC_DW-1:0];
              rc_sof       <= sof_pend_q;
              rc_rel_tag_q <= cpl_tag_q;
              sof_pend_q   <= 1'b0;
              carry_q      <= merged[2*`RTC_DW-1:`RTC_DW];
              if (total > 5'h08)
              begin
                rc_keep  <= {`RTC_NDW{1'b1}};
                rc_last  <= 1'b0;
                rc_rel_q <= 1'b0;
                cnt_q    <= total[3:0] - 4'h8;
                if (lnk_cpl_eop)
                  st_q <= ST_FLUSH;
              end
              else
              begin
                rc_keep  <= (total == 5'h08) ? {`RTC_NDW{1'b1}} : keep_of(total[3:0]);
                rc_last  <= lnk_cpl_eop;
                rc_rel_q <= lnk_cpl_eop & done_q;
                cnt_q    <= 4'h0;
                if (lnk_cpl_eop)
                  st_q <= ST_HDR;
              end
            end
            else
            begin
              carry_q <= merged[`RTC_DW-1:0];
              cnt_q   <= total[3:0];
            end
          end
        end
        ST_FLUSH:
        begin
          if (out_free)
          begin
            rc_valid     <= 1'b1;
            rc_data      <= carry_q;
            rc_keep      <= keep_of(cnt_q);
            rc_sof       <= 1'b0;
            rc_last      <= 1'b1;
            rc_rel_q     <= done_q;
            rc_rel_tag_q <= cpl_tag_q;
            cnt_q        <= 4'h0;
            st_q         <= ST_HDR;
          end
        end
        default:
          st_q <= ST_HDR;
      endcase
    end
  end

  // register bus: one wait cycle, then answer
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      user_tag_q      <= 1'b0;
      rc_aa_q         <= 1'b0;
      rq_aa_q         <= 1'b0;
    end
    else
    begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (!avs_waitrequest && avs_write && avs_address[7:2] == `RTC_REG_CTRL)
      begin
        user_tag_q <= avs_writedata[`RTC_CTRL_USER_TAG];
        rc_aa_q    <= avs_writedata[`RTC_CTRL_RC_AA];
        rq_aa_q    <= avs_writedata[`RTC_CTRL_RQ_AA];
      end
      if (init_q)
        user_tag_q <= (user_tag_select_param != 0); // [R1]
      case (avs_address[7:2])
        `RTC_REG_CTRL:   avs_readdata <= {29'h0, rq_aa_q, rc_aa_q, user_tag_q};
        `RTC_REG_CRED:   avs_readdata <= {16'h0, dat_cnt_q, hdr_cnt_q};
        `RTC_REG_STATUS: avs_readdata <= {dat_cnt_q, hdr_cnt_q, ~init_q, free_cnt,
                                          1'b0, out_cnt_q};
        default:         avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

//--- design/rtc_defs.vh
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// datapath geometry (256-bit streams, eight dwords a beat)
`define RTC_DW          256
`define RTC_NDW         8
`define RTC_TAGS        64
`define RTC_TAG_W       6
`define RTC_CNT_W       7

// completion descriptor layout
`define RTC_DESC_W      96
`define RTC_DESC_DWORDS 4'h3
`define RTC_D_ERR_LO    12
`define RTC_D_BC_LO     16
`define RTC_D_DONE      30
`define RTC_D_DWC_LO    32
`define RTC_D_TAG_LO    64
`define RTC_ERR_NORMAL  4'h0
`define RTC_ERR_BADTAG  4'h6

// request sideband layout
`define RTC_SB_W        8
`define RTC_SB_OFF_LO   0
`define RTC_SB_SEQ_LO   3
`define RTC_SB_SEQ_VLD  7

// register map (word offsets, matched against address bits 7:2)
`define RTC_REG_CTRL    6'h00
`define RTC_REG_CRED    6'h01
`define RTC_REG_STATUS  6'h02
`define RTC_CTRL_USER_TAG 0
`define RTC_CTRL_RC_AA  1
`define RTC_CTRL_RQ_AA  2

// reset values
`define RTC_CRED_HDR_RST  8'h20
`define RTC_CRED_DATA_RST 8'h40

`endif

//--- bench/rtc_top_monitor.sv
module rtc_top_monitor (
  // clock and reset
  input wire         clk,
  input wire         rst_b,
  // request stream
  input wire         rq_valid,
  input wire [255:0] rq_data,
  input wire         rq_last,
  input wire         rq_np,
  input wire         request_stream_accept,
  // reports
  input wire         allocated_tag_strobe,
  input wire [1:0]   np_header_credit_avail,
  input wire         posted_order_token_strobe,
  // link and completion streams
  input wire         lnk_tx_valid,
  input wire         lnk_tx_ready,
  input wire [255:0] lnk_tx_data,
  input wire         rc_valid,
  input wire         rc_ready,
  input wire [255:0] rc_data,
  input wire [7:0]   rc_keep,
  input wire         rc_sof
);
  timeunit 1ns;
  timeprecision 1ns;
  logic first_q;
  wire  take = rq_valid && request_stream_accept;
  // tag and credit work happens on first beats only
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      first_q <= 1'b1;
    else if (take)
      first_q <= rq_last;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  init_hold_a: assert property ($rose(rst_b) |-> (!request_stream_accept) [*8])
    else $error("request accepted during tag init");
  np_tag_a: assert property (take && rq_np && first_q |=> allocated_tag_strobe)
    else $error("no tag reported for non-posted request");
  tag_pulse_a: assert property (allocated_tag_strobe |=> !allocated_tag_strobe)
    else $error("tag strobe longer than one cycle");
  tx_follow_a: assert property (take |=> lnk_tx_valid && lnk_tx_data == $past(rq_data))
    else $error("request beat not forwarded");
  tx_hold_a: assert property (lnk_tx_valid && !lnk_tx_ready |=> lnk_tx_valid
    && $stable(lnk_tx_data))
    else $error("link beat changed while stalled");
  cred_drop_a: assert property (np_header_credit_avail < $past(np_header_credit_avail)
    |-> $past(take && rq_np && first_q, 2))
    else $error("credit fell without request two cycles before");
  tok_pulse_a: assert property (posted_order_token_strobe |=> !posted_order_token_strobe)
    else $error("token strobe longer than one cycle");
  rc_hold_a: assert property (rc_valid && !rc_ready |=> rc_valid && $stable(rc_data)
    && $stable(rc_keep))
    else $error("completion beat changed while stalled");
  sof_desc_a: assert property (rc_valid && rc_sof |-> rc_keep[2:0] == 3'h7)
    else $error("descriptor dwords not kept");
  cover property (allocated_tag_strobe);
  cover property (rq_valid && !request_stream_accept [*8]);
  cover property (rc_valid && rc_ready && rc_sof);
  cover property (posted_order_token_strobe);
endmodule

bind rtc_top rtc_top_monitor i_mon (
  .clk, .rst_b, .rq_valid, .rq_data, .rq_last, .rq_np, .request_stream_accept,
  .allocated_tag_strobe, .np_header_credit_avail, .posted_order_token_strobe,
  .lnk_tx_valid, .lnk_tx_ready, .lnk_tx_data, .rc_valid, .rc_ready, .rc_data,
  .rc_keep, .rc_sof
);

//--- bench/rtc_user_model.sv
module rtc_user_model (
  // clock
  input  wire       clk,
  // tag report and completion stream
  input  wire       allocated_tag_strobe,
  input  wire [5:0] allocated_tag_out,
  output logic      rc_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int         seed = 32'h6768ce5d;
  logic [5:0] tags[$];
  initial rc_ready = 1'b0;
  // random stalls so some completion beats have to stand
  always @(posedge clk)
    rc_ready <= ($random(seed) & 3) != 0;
  // kept in report order to match completions later
  always @(posedge clk)
    if (allocated_tag_strobe === 1'b1)
      tags.push_back(allocated_tag_out);
endmodule

//--- bench/rtc_top_tb.sv
module rtc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [255:0] d; logic [7:0] k; logic [7:0] m; logic [1:0] f;} rtc_beat_t;
  logic         clk = 0, rst_b = 0;
  logic [7:0]   avs_address = 0, request_sideband = 0;
  logic         avs_read = 0, avs_write = 0, rq_valid = 0, rq_last = 1, rq_np = 0;
  logic         rq_has_data = 0, lnk_tx_ready = 0, lnk_np_hdr_ret = 0, lnk_np_data_ret = 0;
  logic         lnk_cpl_valid = 0, lnk_cpl_sop = 0, lnk_cpl_eop = 0;
  logic [31:0]  avs_writedata = 0, r;
  logic [255:0] rq_data = 0, lnk_cpl_data = 0, dm;
  logic [5:0]   rq_ext_tag = 0;
  logic [95:0]  lnk_cpl_desc = 0;
  logic [3:0]   lnk_cpl_dws = 0;
  wire [31:0]   avs_readdata;
  wire [255:0]  lnk_tx_data, rc_data;
  wire [5:0]    allocated_tag_out, lnk_tx_tag;
  wire [1:0]    np_header_credit_avail, np_data_credit_avail;
  wire [3:0]    posted_order_token_out;
  wire [7:0]    rc_keep;
  wire          avs_waitrequest, request_stream_accept, allocated_tag_strobe, rc_ready;
  wire          posted_order_token_strobe, lnk_tx_valid, lnk_tx_first, lnk_tx_last;
  wire          lnk_tx_np, lnk_cpl_ready, rc_valid, rc_last, rc_sof;
  int           seed = 32'h6768ce5d, err_count = 0, check_count = 0;
  int           hdr, dat, outs = 0, tk = -1;
  logic [255:0] exp_tx[$];
  int           exp_tk[$];
  logic [5:0]   lt[$];
  rtc_beat_t    exp_rc[$], b;
  logic [63:0]  busy = 0;

  rtc_top i_rtc_top (
    .clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .rq_valid, .rq_data, .rq_last, .rq_np, .rq_has_data, .rq_ext_tag,
    .request_sideband, .request_stream_accept, .allocated_tag_out, .allocated_tag_strobe,
    .np_header_credit_avail, .np_data_credit_avail, .posted_order_token_out,
    .posted_order_token_strobe, .lnk_tx_valid, .lnk_tx_ready, .lnk_tx_data, .lnk_tx_first,
    .lnk_tx_last, .lnk_tx_np, .lnk_tx_tag, .lnk_np_hdr_ret, .lnk_np_data_ret,
    .lnk_cpl_valid, .lnk_cpl_ready, .lnk_cpl_sop, .lnk_cpl_desc, .lnk_cpl_data,
    .lnk_cpl_dws, .lnk_cpl_eop, .rc_valid, .rc_ready, .rc_data, .rc_keep, .rc_last, .rc_sof
  );
  rtc_user_model i_user (.clk, .allocated_tag_strobe, .allocated_tag_out, .rc_ready);

  always #10 clk = ~clk;
  // a congested link, so beats wait in the output stage
  always @(posedge clk)
    lnk_tx_ready <= ($random(seed) & 3) != 0;

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [1:0] cd(input int n);
    return n > 2 ? 2'h3 : 2'(n);
  endfunction

  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic st();
    av(1'b0, 8'h08, 32'h0);
    check(r[15:0], {1'b1, 7'(64 - outs), 1'b0, 7'(outs)});
  endtask

  task automatic rq_start(input logic np, input logic [7:0] sb);
    rq_valid <= 1'b1;
    rq_np <= np;
    rq_has_data <= np;
    rq_data <= {8{$random(seed)}};
    request_sideband <= sb;
  endtask

  task automatic rq_wait();
    do @(posedge clk); while (request_stream_accept !== 1'b1);
    exp_tx.push_back(rq_data);
    exp_tk.push_back(!rq_np && request_sideband[7] ? int'(request_sideband[6:3]) : -1);
    if (rq_np)
    begin
      hdr--;
      dat--;
      outs++;
    end
    rq_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rq_send(input logic np, input logic [7:0] sb);
    rq_start(np, sb);
    rq_wait();
  endtask

  task automatic refuse();
    repeat (10)
    begin
      @(posedge clk);
      check(request_stream_accept, 0);
    end
  endtask

  task automatic cpl(input logic [5:0] tg, input int bc, dwc, input logic dn, input int off);
    logic [95:0]  d;
    logic [255:0] pl;
    d = {26'h0, tg, 21'h0, 11'(dwc), 3'h0, 13'(bc), 16'h0};
    pl = {8{$random(seed)}};
    lnk_cpl_valid <= 1'b1;
    lnk_cpl_sop <= 1'b1;
    lnk_cpl_desc <= d;
    lnk_cpl_eop <= dwc == 0;
    do @(posedge clk); while (lnk_cpl_ready !== 1'b1);
    if (dwc > 0)
    begin
      lnk_cpl_sop <= 1'b0;
      lnk_cpl_data <= pl;
      lnk_cpl_dws <= 4'(dwc);
      lnk_cpl_eop <= 1'b1;
      do @(posedge clk); while (lnk_cpl_ready !== 1'b1);
    end
    lnk_cpl_valid <= 1'b0;
    d[30] = dn;
    if (off < 0)
      exp_rc.push_back('{{pl[159:0], d}, (8'h1 << (dwc + 3)) - 8'h1,
                         (8'h1 << (dwc + 3)) - 8'h1, 2'h3});
    else
    begin
      exp_rc.push_back('{256'(d), 8'h07, 8'h07, {1'b1, dwc == 0}});
      // pad dwords before the offset are kept but carry no data
      if (dwc > 0)
        exp_rc.push_back('{pl << (32 * off), (8'h1 << (off + dwc)) - 8'h1,
                           ((8'h1 << dwc) - 8'h1) << off, 2'h1});
    end
    if (dn)
    begin
      busy[tg] = 1'b0;
      outs--;
    end
    while (exp_rc.size() > 0) @(posedge clk);
    @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    if (tk >= 0)
    begin
      check(posted_order_token_strobe, 1);
      check(posted_order_token_out, tk);
    end
    tk = -1;
    if (lnk_tx_valid === 1'b1 && lnk_tx_ready === 1'b1)
    begin
      check(lnk_tx_data, exp_tx.pop_front());
      tk = exp_tk.pop_front();
      if (lnk_tx_np === 1'b1)
        lt.push_back(lnk_tx_tag);
    end
    if (allocated_tag_strobe === 1'b1)
    begin
      check(busy[allocated_tag_out], 0);
      busy[allocated_tag_out] = 1'b1;
    end
    if (rc_valid === 1'b1 && rc_ready === 1'b1)
    begin
      b = exp_rc.pop_front();
      for (int i = 0; i < 8; i++)
        dm[32 * i +: 32] = {32{b.m[i]}};
      check(rc_keep, b.k);
      check({rc_sof, rc_last}, b.f);
      check(rc_data & dm, b.d & dm);
    end
  end

  initial
  begin
    #1ms;
    err_count++;
    complete_run();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (70) @(posedge clk);
    check(np_header_credit_avail, 2'h3);
    check(np_data_credit_avail, 2'h3);
    av(1'b0, 8'h00, 32'h0);
    check(r, 0);
    av(1'b0, 8'h3c, 32'h0);
    check(r, 0);
    st();
    av(1'b1, 8'h04, 32'h0303);
    hdr = 3;
    dat = 3;
    repeat (3)
    begin
      rq_send(1'b1, 8'h00);
      #1 check(np_header_credit_avail, cd(hdr));
      @(posedge clk);
      #1 check(np_header_credit_avail, cd(hdr));
      check(np_data_credit_avail, cd(dat));
      @(posedge clk);
    end
    rq_start(1'b1, 8'h00);
    refuse();
    lnk_np_hdr_ret <= 1'b1;
    lnk_np_data_ret <= 1'b1;
    @(posedge clk);
    lnk_np_hdr_ret <= 1'b0;
    lnk_np_data_ret <= 1'b0;
    rq_wait();
    av(1'b1, 8'h04, 32'hffff);
    while (outs < 64)
    begin
      rq_send(1'b1, 8'h00);
      if (outs % 16 == 0)
        rq_send(1'b0, {1'b1, 4'(outs / 16), 3'h0});
    end
    rq_start(1'b1, 8'h00);
    refuse();
    st();
    // the held request is taken as soon as the freed tag is back
    fork
      cpl(i_user.tags[0], 0, 0, 1'b1, -1);
      rq_wait();
    join
    cpl(i_user.tags[1], 16, 2, 1'b0, -1);
    st();
    cpl(i_user.tags[1], 8, 2, 1'b1, -1);
    st();
    av(1'b1, 8'h00, 32'h6);
    rq_send(1'b1, 8'h03);
    st();
    cpl(i_user.tags[$], 8, 2, 1'b1, 3);
    while (exp_tx.size() > 0) @(posedge clk);
    check(lt.size(), i_user.tags.size());
    foreach (lt[i])
      check(lt[i], i_user.tags[i]);
    complete_run();
  end
endmodule
